/* hw/adc_port_pkg.sv */
package adc_port_pkg;
  localparam int          NUM_CH        = 4;
  localparam int          DATA_W        = 14;
  localparam int          SEL_W         = 4;
  // conversion length in master clock cycles
  localparam logic [4:0]  CONV_CYCLES   = 5'h10;
  // internal master clock: one tick every INT_CLK_DIV system cycles
  localparam logic [3:0]  INT_CLK_DIV   = 4'h4;
  localparam logic [3:0]  CH_SEL_RESET  = 4'hf;
  localparam logic [1:0]  PTR_FIRST     = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_NEXT = 2'b11
  } conv_state_t;

  typedef struct packed {
    logic [1:0]        ch;
    logic [DATA_W-1:0] data;
  } result_t;
endpackage

/* hw/result_buf2.sv */
`timescale 1ns/10ps
// two-entry skid buffer; a stalled reader loses no result
module result_buf2 (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire adc_port_pkg::result_t in_data,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output adc_port_pkg::result_t      out_data
);
  adc_port_pkg::result_t mem_ff [2];
  logic                  wr_ptr_ff;
  logic                  rd_ptr_ff;
  logic [1:0]            cnt_ff;
  logic                  push;
  logic                  pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule

/* hw/simsample_adc_host_port.sv */
`timescale 1ns/10ps
// Behaviour
// [R1] busy high from start edge until sequence done
// [R2] first flag high while pointer at register one
// [R3] start rising edge holds all four, converts
// [R4] sequence selection latched at start rising edge
// [R5] bus ignored unless chip select low
// [R6] data outputs enabled only with select and read low
// [R7] host keeps write strobe high during reads
// [R8] write rising edge stores data bits three..zero
// [R9] hardware mode: include pin high includes channel
// [R10] source low: pins and internal clock; high: register
// [R11] clock select low internal, high external clock
// [R12] one channel conversion takes sixteen master clocks
// [R13] data outputs high impedance otherwise
module simsample_adc_host_port (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              conversion_start_n,
  input  wire logic                              chip_select_n,
  input  wire logic                              read_n,
  input  wire logic                              write_n,
  input  wire logic [adc_port_pkg::SEL_W-1:0]    data_in,
  output logic      [adc_port_pkg::DATA_W-1:0]   data_out,
  output logic                                   data_oe,
  input  wire logic                              channel_one_include,
  input  wire logic                              channel_two_include,
  input  wire logic                              channel_three_include,
  input  wire logic                              channel_four_include,
  input  wire logic                              sequence_source_select,
  input  wire logic                              clock_source_select,
  input  wire logic                              ext_conv_clk,
  input  wire logic [adc_port_pkg::DATA_W-1:0]   sample_data,
  output logic                                   track_hold_n,
  output logic      [1:0]                        convert_channel,
  output logic                                   busy,
  output logic                                   first_result_flag,
  output logic      [3:0]                        channel_select
);
  // two-flop synchronisers for all pins from outside
  logic [1:0] cs_sy_ff, rd_sy_ff, wr_sy_ff, cv_sy_ff, xc_sy_ff;
  logic [3:0] inc_s1_ff, inc_s2_ff;
  logic       src_s1_ff, src_s2_ff, cks_s1_ff, cks_s2_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_sy_ff  <= 2'h3;
      rd_sy_ff  <= 2'h3;
      wr_sy_ff  <= 2'h3;
      cv_sy_ff  <= 2'h3;
      xc_sy_ff  <= 2'h0;
      inc_s1_ff <= 4'h0;
      inc_s2_ff <= 4'h0;
      src_s1_ff <= 1'b0;
      src_s2_ff <= 1'b0;
      cks_s1_ff <= 1'b0;
      cks_s2_ff <= 1'b0;
    end else begin
      cs_sy_ff  <= {cs_sy_ff[0], chip_select_n};
      rd_sy_ff  <= {rd_sy_ff[0], read_n};
      wr_sy_ff  <= {wr_sy_ff[0], write_n};
      cv_sy_ff  <= {cv_sy_ff[0], conversion_start_n};
      xc_sy_ff  <= {xc_sy_ff[0], ext_conv_clk};
      inc_s1_ff <= {channel_four_include, channel_three_include,
                    channel_two_include, channel_one_include};
      inc_s2_ff <= inc_s1_ff;
      src_s1_ff <= sequence_source_select;
      src_s2_ff <= src_s1_ff;
      cks_s1_ff <= clock_source_select;
      cks_s2_ff <= cks_s1_ff;
    end
  end

  // previous synced values for edge detection (read only second stage)
  logic cv_prev_ff, wr_prev_ff, rd_prev_ff, xc_prev_ff, cs_prev_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cv_prev_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      xc_prev_ff <= 1'b0;
    end else begin
      cv_prev_ff <= cv_sy_ff[1];
      cs_prev_ff <= cs_sy_ff[1];
      wr_prev_ff <= wr_sy_ff[1];
      rd_prev_ff <= rd_sy_ff[1];
      xc_prev_ff <= xc_sy_ff[1];
    end
  end

  logic selected;
  logic start_rise;
  logic wr_rise;
  logic rd_rise;
  assign selected   = !cs_sy_ff[1]; // [R5]
  assign start_rise = cv_sy_ff[1] && !cv_prev_ff;
  assign wr_rise    = wr_sy_ff[1] && !wr_prev_ff;
  assign rd_rise    = rd_sy_ff[1] && !rd_prev_ff;

  // channel-select register; data taken from the pins unsynchronised is
  // avoided by sampling the synced bus two cycles after the strobe
  logic [3:0] db_s1_ff, db_s2_ff, ch_sel_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      db_s1_ff  <= 4'h0;
      db_s2_ff  <= 4'h0;
      ch_sel_ff <= adc_port_pkg::CH_SEL_RESET;
    end else begin
      db_s1_ff <= data_in;
      db_s2_ff <= db_s1_ff;
      // chip select may rise with the strobe, so the select seen before the edge counts
      if (wr_rise && !cs_prev_ff && rd_sy_ff[1]) begin
        ch_sel_ff <= db_s2_ff; // [R8] [R5] [R7]
      end
    end
  end
  assign channel_select = ch_sel_ff;

  // master clock tick: internal divider or external clock edge
  logic [3:0] div_ff;
  logic       int_tick;
  logic       ext_mode_ff;
  logic       tick;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_ff <= 4'h0;
    end else if (div_ff == adc_port_pkg::INT_CLK_DIV - 4'h1) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end
  assign int_tick = (div_ff == adc_port_pkg::INT_CLK_DIV - 4'h1);
  // hardware sequence mode always runs off the internal clock
  assign tick = ext_mode_ff ? (xc_sy_ff[1] && !xc_prev_ff) : int_tick; // [R11] [R10]

  // conversion sequencer
  adc_port_pkg::conv_state_t state_ff;
  logic [3:0]  seq_ff;
  logic [1:0]  ch_ff;
  logic [4:0]  cyc_ff;
  logic [3:0]  nxt_seq;
  logic        push_valid, push_ready;
  adc_port_pkg::result_t push_data;

  // latch selection once at the start edge
  always_comb begin
    nxt_seq = src_s2_ff ? ch_sel_ff : inc_s2_ff; // [R10] [R9] [R4]
  end

  function automatic logic [1:0] first_set(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff    <= adc_port_pkg::ST_IDLE;
      seq_ff      <= 4'h0;
      ch_ff       <= 2'h0;
      cyc_ff      <= 5'h0;
      ext_mode_ff <= 1'b0;
    end else begin
      case (state_ff)
        adc_port_pkg::ST_IDLE: begin
          if (start_rise && nxt_seq != 4'h0) begin
            seq_ff      <= nxt_seq; // [R4]
            ch_ff       <= first_set(nxt_seq);
            cyc_ff      <= 5'h0;
            ext_mode_ff <= src_s2_ff && cks_s2_ff; // [R11]
            state_ff    <= adc_port_pkg::ST_CONV; // [R3]
          end
        end
        adc_port_pkg::ST_CONV: begin
          if (tick) begin
            if (cyc_ff == adc_port_pkg::CONV_CYCLES - 5'h1) begin
              state_ff <= adc_port_pkg::ST_NEXT; // [R12]
            end else begin
              cyc_ff <= cyc_ff + 5'h1;
            end
          end
        end
        adc_port_pkg::ST_NEXT: begin
          // waits here while the result buffer is full
          if (push_ready) begin
            seq_ff[ch_ff] <= 1'b0;
            cyc_ff        <= 5'h0;
            if ((seq_ff & ~(4'h1 << ch_ff)) == 4'h0) begin
              state_ff <= adc_port_pkg::ST_IDLE;
            end else begin
              ch_ff    <= first_set(seq_ff & ~(4'h1 << ch_ff));
              state_ff <= adc_port_pkg::ST_CONV;
            end
          end
        end
        default: state_ff <= adc_port_pkg::ST_IDLE;
      endcase
    end
  end

  assign push_valid      = (state_ff == adc_port_pkg::ST_NEXT);
  assign push_data.ch    = ch_ff;
  assign push_data.data  = sample_data;
  assign busy            = (state_ff != adc_port_pkg::ST_IDLE); // [R1]
  assign track_hold_n    = busy; // high holds all four stages [R3]
  assign convert_channel = ch_ff;

  // result buffer; each host read that was shown a result pops it
  logic                  pop_valid;
  adc_port_pkg::result_t pop_data;
  logic                  pop_ready;
  logic                  dvalid_ff;
  // select seen before the read edge, as it may rise with the strobe;
  // only a word the host was shown is popped, so a late push is not lost
  assign pop_ready = rd_rise && !cs_prev_ff && dvalid_ff; // [R5]

  result_buf2 u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // output pointer: reset to register one at each start
  logic [1:0] ptr_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_ff <= adc_port_pkg::PTR_FIRST;
    end else if (start_rise && state_ff == adc_port_pkg::ST_IDLE) begin
      ptr_ff <= adc_port_pkg::PTR_FIRST;
    end else if (pop_ready && pop_valid) begin
      ptr_ff <= ptr_ff + 2'h1;
    end
  end
  assign first_result_flag = (ptr_ff == adc_port_pkg::PTR_FIRST); // [R2]

  // registered data, frozen while the bus is enabled; enable needs select and read low
  logic [adc_port_pkg::DATA_W-1:0] dout_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_ff   <= '0;
      dvalid_ff <= 1'b0;
    end else if (!data_oe) begin
      dout_ff   <= pop_valid ? pop_data.data : '0;
      dvalid_ff <= pop_valid;
    end
  end
  assign data_out = dout_ff;
  assign data_oe  = selected && !rd_sy_ff[1]; // [R6] [R13]
endmodule

/* verification/adc_port_asserts.sv */
`timescale 1ns/10ps
// pin-level checks; latencies include the two-flop input sync
module adc_port_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       conversion_start_n,
  input wire logic       chip_select_n,
  input wire logic       read_n,
  input wire logic       write_n,
  input wire logic       data_oe,
  input wire logic       channel_one_include,
  input wire logic       channel_two_include,
  input wire logic       channel_three_include,
  input wire logic       channel_four_include,
  input wire logic       sequence_source_select,
  input wire logic       busy,
  input wire logic       first_result_flag,
  input wire logic       track_hold_n,
  input wire logic [3:0] channel_select
);
  logic [15:0] busy_len_ff;
  logic        sel_any;
  // selection that a start edge would latch now
  assign sel_any = sequence_source_select ? |channel_select :
    |{channel_four_include, channel_three_include, channel_two_include, channel_one_include};
  // busy period length, saturating so a long stall cannot wrap
  always_ff @(posedge clk) begin
    if (!rst_n || !busy) busy_len_ff <= 16'h0;
    else if (busy_len_ff != 16'hffff) busy_len_ff <= busy_len_ff + 16'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_strobes: assert property (data_oe == $past(!chip_select_n && !read_n, 2))
    else $error("data enable does not follow select and read");
  a_busy_start: assert property ($rose(conversion_start_n) && !busy && sel_any |-> ##[2:4] busy)
    else $error("busy missing after start edge");
  a_hold_busy: assert property (track_hold_n == busy)
    else $error("hold not tied to sequence");
  a_busy_len: assert property ($fell(busy) |-> busy_len_ff >= 16'h3c)
    else $error("sequence shorter than one conversion");
  a_first_start: assert property ($rose(busy) |-> ##[0:1] first_result_flag)
    else $error("pointer not at first after start");
  a_first_read: assert property ($fell(first_result_flag) |-> !$past(read_n, 4) || !$past(read_n, 5))
    else $error("first flag dropped without a read");
  a_sel_write: assert property ($changed(channel_select) |-> !$past(write_n, 4) || !$past(write_n, 5))
    else $error("select register changed without write");
  a_sel_chip: assert property ($changed(channel_select) |-> !$past(chip_select_n, 4) && $past(read_n, 3))
    else $error("select register written while deselected or reading");
endmodule

bind simsample_adc_host_port adc_port_asserts asserts_u (
  .clk, .rst_n, .conversion_start_n, .chip_select_n, .read_n, .write_n, .data_oe,
  .channel_one_include, .channel_two_include, .channel_three_include, .channel_four_include,
  .sequence_source_select, .busy, .first_result_flag, .track_hold_n, .channel_select
);

/* verification/host_model.sv */
`timescale 1ns/10ps
// host side of the parallel port; strobes move on falling clock edges
module host_model (
  input  wire logic        clk,
  input  wire logic [13:0] data_out,
  input  wire logic        data_oe,
  output logic             chip_select_n,
  output logic             read_n,
  output logic             write_n,
  output logic [3:0]       data_in
);
  initial begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    data_in = 4'h0;
  end
  // rd_low is a deliberately bad host for refusal cases
  task automatic wr(input logic [3:0] v, input logic sel, input logic rd_low);
    @(negedge clk);
    chip_select_n = !sel;
    read_n = !rd_low;
    write_n = 1'b0;
    data_in = v;
    repeat (3) @(negedge clk);
    write_n = 1'b1;
    repeat (4) @(negedge clk); // data held past the synced edge
    chip_select_n = 1'b1;
    read_n = 1'b1;
    data_in = ~v; // released bus shows no stale value
  endtask
  // one read; write strobe stays high throughout
  task automatic rd(output logic [13:0] d, output logic oe);
    @(negedge clk);
    chip_select_n = 1'b0;
    read_n = 1'b0;
    repeat (3) @(negedge clk);
    oe = data_oe;
    d = data_out;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    repeat (4) @(negedge clk); // gap so the rising edge is seen
  endtask
endmodule

/* verification/simsample_adc_host_port_bench.sv */
`timescale 1ns/10ps
module simsample_adc_host_port_bench;
  logic        clk, rst_n, cst, chip_select_n, read_n, write_n, data_oe, busy;
  logic        sequence_source_select, clock_source_select, ext_conv_clk;
  logic        track_hold_n, first_result_flag, ok;
  logic [3:0]  data_in, channel_select, inc, reg_v;
  logic [13:0] data_out, sample_data, d;
  logic [1:0]  convert_channel;
  logic [11:0] base;
  integer      seed = 32'h0571;
  int          bad_count = 0;
  int          num_checks = 0;
  int          n;

  simsample_adc_host_port dut_u (.clk, .rst_n, .conversion_start_n(cst), .chip_select_n,
    .read_n, .write_n, .data_in, .data_out, .data_oe, .channel_one_include(inc[0]),
    .channel_two_include(inc[1]), .channel_three_include(inc[2]),
    .channel_four_include(inc[3]), .sequence_source_select, .clock_source_select,
    .ext_conv_clk, .sample_data, .track_hold_n, .convert_channel, .busy,
    .first_result_flag, .channel_select);
  host_model host_u (.clk, .data_out, .data_oe, .chip_select_n, .read_n, .write_n, .data_in);

  always #5 clk = ~clk;
  // converter core stand-in: each word carries its own channel number
  always @(negedge clk) sample_data <= {base, convert_channel};
  // external master clock, period 8 cycles, slower than the internal tick
  always @(negedge clk) ext_conv_clk <= ($time % 80) >= 40;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // selection in force: register or include pins
  function automatic logic [3:0] mask(input logic s, input logic [3:0] r, input logic [3:0] p);
    return s ? r : p;
  endfunction

  // one sequence; m is the expected selection
  task automatic run(input logic [3:0] m);
    n = 0;
    @(negedge clk) cst = 1'b0;
    @(negedge clk) cst = 1'b1;
    repeat (6) @(negedge clk);
    chk(busy, |m);
    inc = ~inc;
    if (|m) begin
      @(negedge clk) cst = 1'b0; // start while busy must be ignored
      @(negedge clk) cst = 1'b1;
    end
    if (sequence_source_select) host_u.wr(~m, 1'b1, 1'b0);
    repeat (300) @(negedge clk); // reader stalls, buffer fills
    chk(busy, $countones(m) > 2);
    for (int c = 0; c < 4; c++) begin
      if (m[c]) begin
        chk(first_result_flag, n == 0);
        d = 14'h0;
        for (int k = 0; k < 40 && d == 14'h0; k++) host_u.rd(d, ok);
        chk(ok, 1'b1);
        chk(d, {base, c[1:0]});
        n++;
      end
    end
    repeat (150) @(negedge clk);
    chk(busy, 1'b0);
    host_u.rd(d, ok);
    chk(d, 14'h0);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cst = 1'b1;
    sequence_source_select = 1'b0;
    clock_source_select = 1'b0;
    inc = 4'h0;
    base = 12'h800;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(busy, 1'b0);
    chk(first_result_flag, 1'b1);
    chk(data_oe, 1'b0);
    chk(channel_select, 4'hf);
    host_u.wr(4'h3, 1'b0, 1'b0);
    chk(channel_select, 4'hf);
    host_u.wr(4'h5, 1'b1, 1'b1);
    chk(channel_select, 4'hf);
    for (int i = 0; i < 12; i++) begin
      base = 12'h800 | 12'($random(seed));
      sequence_source_select = (i > 0) && 1'($random(seed));
      clock_source_select = 1'($random(seed));
      inc = (i == 0) ? 4'h0 : 4'($random(seed));
      if (sequence_source_select) begin
        reg_v = (i < 4) ? 4'hf : 4'($random(seed));
        host_u.wr(reg_v, 1'b1, 1'b0);
        chk(channel_select, reg_v);
      end
      run(mask(sequence_source_select, reg_v, inc));
    end
    end_sim();
  end

  // watchdog: twelve sequences take well under this
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
endmodule
